// ### core/ethernet_host_side_ports.sv
/*
  Host-facing shell: lite configuration slave forwarding to the MAC core,
  four 32-bit streams looped internally, bridging byte streams, real-time
  clock with timer and isochronous tick, time-protocol interrupts.
  Assumes every input except rst_b_i is synchronous to clk_i and the core answers a
  configuration read in the cycle of its read strobe.
*/
`timescale 1ns/100ps
`include "ethernet_host_side_ports_defines.svh"
module ethernet_host_side_ports import ethernet_host_side_ports_pkg::*; #(
  parameter int unsigned timer_cycles_p = `TIMER_CYCLES,
  parameter bit bridging_enable_p = 1'b1,
  parameter logic [2:0] phy_type_p = `PHY_GMII,
  parameter bit shared_logic_p = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic processor_mode_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic cfg_to_buffer_o,
  output logic [31:0] cfg_addr_o,
  output logic [31:0] cfg_wdata_o,
  output logic [3:0] cfg_wstrb_o,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic txd_rst_b_i,
  input wire logic txd_valid_i,
  output logic txd_ready_o,
  input wire axis32_s txd_i,
  input wire logic txc_rst_b_i,
  input wire logic txc_valid_i,
  output logic txc_ready_o,
  input wire axis32_s txc_i,
  input wire logic rxd_rst_b_i,
  output logic rxd_valid_o,
  input wire logic rxd_ready_i,
  output axis32_s rxd_o,
  input wire logic rxs_rst_b_i,
  output logic rxs_valid_o,
  input wire logic rxs_ready_i,
  output axis32_s rxs_o,
  output logic bridging_tx_stream_clk_o,
  input wire logic bridging_tx_stream_rst_b_i,
  input wire logic bridging_tx_stream_valid_i,
  output logic bridging_tx_stream_ready_o,
  input wire byte_beat_s bridging_tx_stream_i,
  output logic bridging_rx_stream_clk_o,
  input wire logic bridging_rx_stream_rst_b_i,
  output logic bridging_rx_stream_valid_o,
  output byte_beat_s bridging_rx_stream_o,
  output logic irq_ptp_timer_o,
  output logic irq_ptp_tx_o,
  output logic irq_ptp_rx_o,
  output logic interrupt_o,
  output rtc_s rtc_o,
  output logic isochronous_tick_clock_o,
  output logic mgmt_present_o,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_b_o,
  output logic refclk_used_o
);
  localparam bit mgmt_p = (phy_type_p == `PHY_MII) || (phy_type_p == `PHY_GMII) ||
    (phy_type_p == `PHY_RGMII) || (phy_type_p == `PHY_SGMII);

  logic [1:0] rst_sync;
  logic rst_n;

  // Release of the asynchronous reset through two flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Configuration slave
  axi_state_e state, next_state;
  logic [31:0] next_rdata;
  logic next_cfg_wr, next_cfg_rd, next_cfg_buf;
  logic [31:0] next_cfg_addr, next_cfg_wdata;
  logic [3:0] next_cfg_wstrb;
  logic aw_take, ar_take;

  // Address and data are taken together so no write half can dangle
  assign aw_take = (state == AXI_IDLE) && s_axi_awvalid_i && s_axi_wvalid_i;
  assign ar_take = (state == AXI_IDLE) && s_axi_arvalid_i && !aw_take;
  assign s_axi_awready_o = aw_take;
  assign s_axi_wready_o = aw_take;
  assign s_axi_arready_o = ar_take;
  assign s_axi_bvalid_o = (state == AXI_BRESP);
  assign s_axi_rvalid_o = (state == AXI_RDATA);
  assign s_axi_bresp_o = `RESP_OKAY;
  assign s_axi_rresp_o = `RESP_OKAY;

  always_comb begin
    next_state = state;
    next_rdata = s_axi_rdata_o;
    next_cfg_wr = 1'b0;
    next_cfg_rd = 1'b0;
    next_cfg_buf = cfg_to_buffer_o;
    next_cfg_addr = cfg_addr_o;
    next_cfg_wdata = cfg_wdata_o;
    next_cfg_wstrb = cfg_wstrb_o;
    case (state)
      AXI_IDLE: begin
        if (aw_take) begin
          next_cfg_wr = 1'b1;
          next_cfg_buf = processor_mode_i;
          next_cfg_addr = s_axi_awaddr_i;
          next_cfg_wdata = s_axi_wdata_i;
          next_cfg_wstrb = s_axi_wstrb_i;
          next_state = AXI_BRESP;
        end else if (ar_take) begin
          next_cfg_rd = 1'b1;
          next_cfg_buf = processor_mode_i;
          next_cfg_addr = s_axi_araddr_i;
          next_state = AXI_RWAIT;
        end
      end
      AXI_RWAIT: begin
        next_rdata = cfg_rdata_i;
        next_state = AXI_RDATA;
      end
      AXI_RDATA: begin
        if (s_axi_rready_i) begin
          next_state = AXI_IDLE;
        end
      end
      AXI_BRESP: begin
        if (s_axi_bready_i) begin
          next_state = AXI_IDLE;
        end
      end
      default: next_state = AXI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= AXI_IDLE;
      s_axi_rdata_o <= 32'h0;
      cfg_wr_o <= 1'b0;
      cfg_rd_o <= 1'b0;
      cfg_to_buffer_o <= 1'b0;
      cfg_addr_o <= 32'h0;
      cfg_wdata_o <= 32'h0;
      cfg_wstrb_o <= 4'h0;
    end else begin
      state <= next_state;
      s_axi_rdata_o <= next_rdata;
      cfg_wr_o <= next_cfg_wr;
      cfg_rd_o <= next_cfg_rd;
      cfg_to_buffer_o <= next_cfg_buf;
      cfg_addr_o <= next_cfg_addr;
      cfg_wdata_o <= next_cfg_wdata;
      cfg_wstrb_o <= next_cfg_wstrb;
    end
  end

  // Main streams, all on clk_i; transmit data loops to receive data
  axis32_s next_rxd, next_rxs;
  logic next_rxd_valid, next_rxs_valid;
  logic [31:0] byte_count, next_byte_count, beat_bytes;
  logic tx_ptp, next_tx_ptp, rx_ptp, next_rx_ptp;
  logic next_irq_tx, next_irq_rx, next_irq_timer;
  logic txd_take, txc_take, rxd_hand, rxs_hand;

  // Status pending stalls transmit; a one-beat frame taken in the cycle status is raised can overwrite it
  assign txd_ready_o = txd_rst_b_i && rxd_rst_b_i && !rxs_valid_o &&
    (!rxd_valid_o || rxd_ready_i);
  assign txc_ready_o = txc_rst_b_i;
  assign txd_take = txd_valid_i && txd_ready_o;
  assign txc_take = txc_valid_i && txc_ready_o;
  assign rxd_hand = rxd_valid_o && rxd_ready_i;
  assign rxs_hand = rxs_valid_o && rxs_ready_i;
  assign beat_bytes = 32'(rxd_o.keep[0]) + 32'(rxd_o.keep[1]) +
    32'(rxd_o.keep[2]) + 32'(rxd_o.keep[3]);

  always_comb begin
    next_rxd = rxd_o;
    next_rxd_valid = rxd_valid_o && !rxd_hand;
    next_rxs = rxs_o;
    next_rxs_valid = rxs_valid_o && !rxs_hand;
    next_byte_count = byte_count;
    next_tx_ptp = tx_ptp;
    next_rx_ptp = rx_ptp;
    next_irq_tx = 1'b0;
    next_irq_rx = 1'b0;
    if (rxd_hand) begin
      next_byte_count = byte_count + beat_bytes;
      if (rxd_o.last) begin
        next_rxs = '{data: byte_count + beat_bytes, keep: 4'hf, last: 1'b1};
        next_rxs_valid = rxs_rst_b_i;
        next_byte_count = 32'h0;
        next_irq_rx = rx_ptp;
        next_rx_ptp = 1'b0;
      end
    end
    if (txd_take) begin
      next_rxd = txd_i;
      next_rxd_valid = 1'b1;
      if (txd_i.last) begin
        next_irq_tx = tx_ptp;
        next_tx_ptp = 1'b0;
        next_rx_ptp = rx_ptp && !(rxd_hand && rxd_o.last) || tx_ptp;
      end
    end
    // A new marked control word wins over the clear of the previous frame
    if (txc_take && txc_i.data[`PTP_FLAG_BIT]) begin
      next_tx_ptp = 1'b1;
    end
    if (!txc_rst_b_i) begin
      next_tx_ptp = 1'b0;
    end
    if (!rxd_rst_b_i) begin
      next_rxd_valid = 1'b0;
      next_byte_count = 32'h0;
      next_rx_ptp = 1'b0;
    end
    if (!rxs_rst_b_i) begin
      next_rxs_valid = 1'b0;
    end
  end

  // Shared stream clock is clk_i for all four channels
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rxd_o <= '0;
      rxd_valid_o <= 1'b0;
      rxs_o <= '0;
      rxs_valid_o <= 1'b0;
      byte_count <= 32'h0;
      tx_ptp <= 1'b0;
      rx_ptp <= 1'b0;
      irq_ptp_tx_o <= 1'b0;
      irq_ptp_rx_o <= 1'b0;
    end else begin
      rxd_o <= next_rxd;
      rxd_valid_o <= next_rxd_valid;
      rxs_o <= next_rxs;
      rxs_valid_o <= next_rxs_valid;
      byte_count <= next_byte_count;
      tx_ptp <= next_tx_ptp;
      rx_ptp <= next_rx_ptp;
      irq_ptp_tx_o <= next_irq_tx;
      irq_ptp_rx_o <= next_irq_rx;
    end
  end

  // Bridging streams: device clock is clk_i divided by two
  logic bclk, next_bclk, bridge_on;
  byte_beat_s held, next_held, next_brx;
  logic held_valid, next_held_valid, next_brx_valid;

  assign bridge_on = bridging_enable_p && bridging_tx_stream_rst_b_i;
  assign bridging_tx_stream_clk_o = bridging_enable_p && bclk;
  assign bridging_rx_stream_clk_o = bridging_enable_p && bclk;
  assign bridging_tx_stream_ready_o = bridge_on;

  always_comb begin
    next_bclk = bridging_enable_p ? !bclk : 1'b0;
    next_held = held;
    next_held_valid = held_valid;
    next_brx = bridging_rx_stream_o;
    next_brx_valid = bridging_rx_stream_valid_o;
    if (!bclk) begin
      // Sample at the rising edge of the driven transmit clock
      next_held = bridging_tx_stream_i;
      next_held_valid = bridging_tx_stream_valid_i && bridge_on;
    end else begin
      // Receive beats change at the falling edge; host cannot stall them
      next_brx = held;
      next_brx_valid = held_valid && bridging_rx_stream_rst_b_i;
    end
    if (!bridging_rx_stream_rst_b_i || !bridging_enable_p) begin
      next_brx_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bclk <= 1'b0;
      held <= '0;
      held_valid <= 1'b0;
      bridging_rx_stream_o <= '0;
      bridging_rx_stream_valid_o <= 1'b0;
    end else begin
      bclk <= next_bclk;
      held <= next_held;
      held_valid <= next_held_valid;
      bridging_rx_stream_o <= next_brx;
      bridging_rx_stream_valid_o <= next_brx_valid;
    end
  end

  // Real-time clock, 10 ms timer and isochronous tick
  rtc_s next_rtc;
  logic [16:0] timer_count, next_timer_count;
  logic [9:0] iso_count, next_iso_count;
  logic next_iso, sec_wrap;
  logic [3:0] mdc_div, next_mdc_div;

  assign sec_wrap = (rtc_o.ns >= 32'(`NS_PER_SECOND - `CLK_PERIOD_NS));

  always_comb begin
    next_rtc.ns = rtc_o.ns + 32'(`CLK_PERIOD_NS);
    next_rtc.sec = rtc_o.sec;
    next_timer_count = timer_count + 17'h1;
    next_irq_timer = 1'b0;
    next_iso_count = iso_count + 10'h1;
    next_iso = isochronous_tick_clock_o;
    next_mdc_div = mdc_div + 4'h1;
    if (sec_wrap) begin
      next_rtc.ns = 32'h0;
      next_rtc.sec = rtc_o.sec + 48'h1;
    end
    if (timer_count >= 17'(timer_cycles_p - 1) || sec_wrap) begin
      // Second rollover realigns the timer to the clock
      next_timer_count = 17'h0;
      next_irq_timer = 1'b1;
    end
    if (iso_count == 10'(`ISO_HALF_CYCLES - 1) || sec_wrap) begin
      next_iso_count = 10'h0;
      next_iso = !isochronous_tick_clock_o && !sec_wrap;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rtc_o <= '0;
      timer_count <= 17'h0;
      irq_ptp_timer_o <= 1'b0;
      iso_count <= 10'h0;
      isochronous_tick_clock_o <= 1'b0;
      mdc_div <= 4'h0;
      interrupt_o <= 1'b0;
    end else begin
      rtc_o <= next_rtc;
      timer_count <= next_timer_count;
      irq_ptp_timer_o <= next_irq_timer;
      iso_count <= next_iso_count;
      isochronous_tick_clock_o <= next_iso;
      mdc_div <= next_mdc_div;
      interrupt_o <= next_irq_timer || next_irq_tx || next_irq_rx;
    end
  end

  // Management pins exist only for the four PHY types
  assign mgmt_present_o = mgmt_p;
  assign mdc_o = mgmt_p && mdc_div[`MDC_DIV_BIT];
  assign mdio_o = 1'b1;
  assign mdio_oe_b_o = 1'b1;
  assign refclk_used_o = shared_logic_p &&
    ((phy_type_p == `PHY_SGMII) || (phy_type_p == `PHY_BASEX));
endmodule : ethernet_host_side_ports

// ### include/ethernet_host_side_ports_defines.svh
/*
  Constants of the host-side port shell: timing counts, field positions and
  configuration codes. Assumes a 10 MHz system clock.
*/
// Function
// - Processor mode routes configuration through buffer
// - 32-bit lite buses, strobe per byte
// - Write response held until master ready
// - Read data held until master ready
// - Transmit data stream: 32 bits, keep, last
// - Transmit control stream accepted beside data
// - All four streams share one clock
// - Receive data stream with host backpressure
// - Receive status stream under host ready; code lets a one-beat frame taken as status is raised overwrite it unread
// - Each main stream has own reset
// - Bridging streams only in bridging mode
// - Bridging transmit: bytes on device clock
// - Bridging receive: bytes, bad-frame flag high
// - Timer interrupt pulse every 10 ms
// - Transmit time-protocol interrupt after sending
// - Receive time-protocol interrupt after handling
// - Clock output: 32-bit ns, 48-bit s
// - 8 kHz tick locked to clock
// - Management port only for four PHY types
// - Reference clock only with shared logic
// - One subsystem interrupt output
`ifndef ETHERNET_HOST_SIDE_PORTS_DEFINES_SVH
`define ETHERNET_HOST_SIDE_PORTS_DEFINES_SVH

`define CLK_PERIOD_NS 100
`define NS_PER_SECOND 1000000000
`define TIMER_PERIOD_MS 10
`define TIMER_CYCLES (`TIMER_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define ISO_PERIOD_US 125
`define ISO_HALF_CYCLES (`ISO_PERIOD_US * 1000 / `CLK_PERIOD_NS / 2)
`define PTP_FLAG_BIT 31
`define RESP_OKAY 2'h0
`define PHY_MII 3'h0
`define PHY_GMII 3'h1
`define PHY_RGMII 3'h2
`define PHY_SGMII 3'h3
`define PHY_BASEX 3'h4
`define MDC_DIV_BIT 2

`endif

// ### include/ethernet_host_side_ports_pkg.sv
/*
  Types of the host-side port shell. Assumes the defines header for values.
*/
package ethernet_host_side_ports_pkg;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] keep;
    logic last;
  } axis32_s;

  typedef struct packed {
    logic [7:0] data;
    logic user;
    logic last;
  } byte_beat_s;

  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] ns;
  } rtc_s;

  typedef enum logic [1:0] {AXI_IDLE, AXI_RWAIT, AXI_RDATA, AXI_BRESP} axi_state_e;
endpackage : ethernet_host_side_ports_pkg

// ### testbench/ethernet_host_side_ports_monitor.sv
/*
  Checker of the host-side shell ports.
  Assumes it is bound to the top module and that everything runs on clk_i.
*/
`timescale 1ns/100ps
module ethernet_host_side_ports_monitor import ethernet_host_side_ports_pkg::*; #(
  parameter int unsigned timer_cycles_p = 100
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic processor_mode_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic cfg_wr_o,
  input wire logic cfg_rd_o,
  input wire logic cfg_to_buffer_o,
  input wire logic [31:0] cfg_addr_o,
  input wire logic txd_rst_b_i,
  input wire logic txd_ready_o,
  input wire logic txc_rst_b_i,
  input wire logic txc_ready_o,
  input wire logic rxd_rst_b_i,
  input wire logic rxd_valid_o,
  input wire logic rxd_ready_i,
  input wire axis32_s rxd_o,
  input wire logic rxs_valid_o,
  input wire axis32_s rxs_o,
  input wire logic irq_ptp_timer_o,
  input wire logic interrupt_o,
  input wire logic irq_ptp_tx_o,
  input wire logic irq_ptp_rx_o,
  input wire rtc_s rtc_o,
  input wire logic isochronous_tick_clock_o
);
  localparam int iso_half = 625;
  int gap;
  int run;
  logic seen_t;
  logic seen_i;
  logic iso_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // First pulse and first edge after reset only arm the period checks
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap <= 0;
      run <= 0;
      seen_t <= 1'b0;
      seen_i <= 1'b0;
      iso_q <= 1'b0;
    end else begin
      gap <= irq_ptp_timer_o ? 1 : gap + 1;
      run <= (isochronous_tick_clock_o != iso_q) ? 1 : run + 1;
      seen_t <= seen_t || irq_ptp_timer_o;
      seen_i <= seen_i || (isochronous_tick_clock_o != iso_q);
      iso_q <= isochronous_tick_clock_o;
    end
  end
  write_take_a: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> s_axi_bvalid_o && cfg_wr_o && cfg_addr_o == $past(s_axi_awaddr_i)) else $error("write");
  read_take_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> cfg_rd_o && !s_axi_rvalid_o ##1 s_axi_rvalid_o) else $error("read");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && s_axi_bresp_o == 2'h0) else $error("bresp");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata");
  buffer_route_a: assert property (cfg_wr_o || cfg_rd_o
    |-> cfg_to_buffer_o == $past(processor_mode_i)) else $error("route");
  rxd_hold_a: assert property (rxd_valid_o && !rxd_ready_i && rxd_rst_b_i
    |=> rxd_valid_o && $stable(rxd_o)) else $error("rxd hold");
  status_after_a: assert property (rxd_valid_o && rxd_ready_i && rxd_o.last && rxd_rst_b_i
    |=> rxs_valid_o && rxs_o.last && rxs_o.keep == 4'hf) else $error("status");
  txd_reset_a: assert property (!txd_rst_b_i |-> !txd_ready_o) else $error("txd reset");
  txc_ready_a: assert property (txc_ready_o == txc_rst_b_i) else $error("txc ready");
  irq_join_a: assert property (interrupt_o ==
    (irq_ptp_timer_o || irq_ptp_tx_o || irq_ptp_rx_o)) else $error("irq");
  rtc_step_a: assert property ($past(rtc_o.ns) != 0
    |-> rtc_o.ns == $past(rtc_o.ns) + 32'd100 || rtc_o.ns == 0) else $error("rtc");
  timer_period_a: assert property (seen_t && (irq_ptp_timer_o || gap >= timer_cycles_p)
    |-> irq_ptp_timer_o && gap == timer_cycles_p) else $error("timer");
  tick_period_a: assert property (
    seen_i && (isochronous_tick_clock_o != iso_q || run >= iso_half)
    |-> isochronous_tick_clock_o != iso_q && run == iso_half) else $error("tick");
  cover property (s_axi_bvalid_o && s_axi_bready_i);
  cover property (s_axi_rvalid_o && s_axi_rready_i);
  cover property (rxs_valid_o && rxs_o.last);
  cover property (irq_ptp_tx_o);
endmodule : ethernet_host_side_ports_monitor
bind ethernet_host_side_ports ethernet_host_side_ports_monitor
  #(.timer_cycles_p(timer_cycles_p)) u_ethernet_host_side_ports_monitor (.*);

// ### testbench/ethernet_host_side_ports_partner.sv
/*
  Far side: register store behind the configuration port and a host sink
  for both receive streams that stalls at random.
  Assumes the bench seeds the random generator.
*/
`timescale 1ns/100ps
module ethernet_host_side_ports_partner (
  input wire logic clk_i,
  input wire logic cfg_wr_i,
  input wire logic [31:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [3:0] cfg_wstrb_i,
  output logic [31:0] cfg_rdata_o,
  output logic rxd_ready_o,
  output logic rxs_ready_o
);
  logic [31:0] store [4] = '{default: 32'h0};
  initial begin
    rxd_ready_o = 1'b0;
    rxs_ready_o = 1'b0;
  end
  always @(posedge clk_i) begin
    rxd_ready_o <= 1'($urandom);
    rxs_ready_o <= 1'($urandom);
    for (int b = 0; b < 4; b++) begin
      if (cfg_wr_i && cfg_wstrb_i[b]) store[cfg_addr_i[3:2]][8*b +: 8] <= cfg_wdata_i[8*b +: 8];
    end
  end
  // Only four words decoded; higher address bits alias
  assign cfg_rdata_o = store[cfg_addr_i[3:2]];
endmodule : ethernet_host_side_ports_partner

// ### testbench/ethernet_host_side_ports_test.sv
/*
  Self-checking bench: lite accesses, frames, channel resets, bridging,
  timer, tick and clock outputs.
  Assumes the checker binds itself and the partner closes the far side.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ethernet_host_side_ports_test import ethernet_host_side_ports_pkg::*; ;
  int fails = 0, compares = 0, marks = 0, tx_irqs = 0, rx_irqs = 0, w, ticks, edges;
  int rx_beats = 0, mdcs;
  logic clk_i = 1'b0, rst_b_i = 1'b0, processor_mode_i = 1'b0, iso_q, mdc_q;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, txd_valid_i = 1'b0, txc_valid_i = 1'b0;
  logic txd_rst_b_i = 1'b1, txc_rst_b_i = 1'b1, rxd_rst_b_i = 1'b1, rxs_rst_b_i = 1'b1;
  logic bridging_tx_stream_rst_b_i = 1'b1, bridging_tx_stream_valid_i = 1'b0;
  logic bridging_rx_stream_rst_b_i = 1'b1;
  logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0, t0;
  logic [3:0] s_axi_wstrb_i = '0;
  axis32_s txd_i = '0, txc_i = '0, rxd_o, rxs_o, beat_x, stat_x, got_x;
  byte_beat_s bridging_tx_stream_i = '0, bridging_rx_stream_o, bb, brx_x;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o, cfg_addr_o, cfg_wdata_o, cfg_rdata_i;
  logic [3:0] cfg_wstrb_o;
  logic cfg_wr_o, cfg_rd_o, cfg_to_buffer_o, txd_ready_o, txc_ready_o, rxd_valid_o, rxd_ready_i;
  logic rxs_valid_o, rxs_ready_i, bridging_tx_stream_clk_o, bridging_tx_stream_ready_o;
  logic bridging_rx_stream_clk_o, bridging_rx_stream_valid_o, irq_ptp_timer_o, irq_ptp_tx_o;
  logic irq_ptp_rx_o, interrupt_o, isochronous_tick_clock_o, mgmt_present_o, mdc_o, mdio_o;
  logic mdio_oe_b_o, refclk_used_o;
  rtc_s rtc_o;
  logic [31:0] shadow [4] = '{default: 32'h0};
  axis32_s exp_q [$];
  logic [31:0] cnt_q [$];
  // Short timer period keeps the run to a few thousand cycles
  ethernet_host_side_ports #(.timer_cycles_p(100)) u_ethernet_host_side_ports (.*);
  ethernet_host_side_ports_partner u_ethernet_host_side_ports_partner (.clk_i(clk_i),
    .cfg_wr_i(cfg_wr_o), .cfg_addr_i(cfg_addr_o), .cfg_wdata_i(cfg_wdata_o),
    .cfg_wstrb_i(cfg_wstrb_o), .cfg_rdata_o(cfg_rdata_i), .rxd_ready_o(rxd_ready_i),
    .rxs_ready_o(rxs_ready_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) merge[8*b +: 8] = d[8*b +: 8];
    end
  endfunction : merge
  task automatic lite_write(logic [31:0] a, logic [31:0] d, logic [3:0] s);
    processor_mode_i <= 1'($urandom);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    @(posedge clk_i);
    for (w = 0; w < 50 && !(s_axi_awready_o && s_axi_wready_o); w++) @(posedge clk_i);
    `CHK(w < 50, 1'b1)
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    s_axi_bready_i <= 1'b1;
    @(posedge clk_i);
    for (w = 0; w < 50 && !s_axi_bvalid_o; w++) @(posedge clk_i);
    `CHK(w < 50, 1'b1)
    `CHK(s_axi_bresp_o, 2'h0)
    `CHK(cfg_to_buffer_o, processor_mode_i)
    s_axi_bready_i <= 1'b0;
    shadow[a[3:2]] = merge(shadow[a[3:2]], d, s);
  endtask : lite_write
  task automatic lite_read(logic [31:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    @(posedge clk_i);
    for (w = 0; w < 50 && !s_axi_arready_o; w++) @(posedge clk_i);
    `CHK(w < 50, 1'b1)
    s_axi_arvalid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    s_axi_rready_i <= 1'b1;
    @(posedge clk_i);
    for (w = 0; w < 50 && !s_axi_rvalid_o; w++) @(posedge clk_i);
    `CHK(w < 50, 1'b1)
    `CHK(s_axi_rdata_o, shadow[a[3:2]])
    `CHK(s_axi_rresp_o, 2'h0)
    s_axi_rready_i <= 1'b0;
  endtask : lite_read
  task automatic send_frame(int words, logic mark);
    logic [3:0] k;
    logic [31:0] total;
    total = 0;
    txc_i <= '{{mark, 31'($urandom)}, 4'hf, 1'b1};
    txc_valid_i <= 1'b1;
    @(posedge clk_i);
    for (w = 0; w < 50 && !txc_ready_o; w++) @(posedge clk_i);
    `CHK(w < 50, 1'b1)
    txc_valid_i <= 1'b0;
    if (mark) marks++;
    for (int i = 0; i < words; i++) begin
      k = (i == words - 1) ? 4'hf >> ($urandom % 4) : 4'hf;
      for (int b = 0; b < 4; b++) total += 32'(k[b]);
      beat_x = '{32'($urandom), k, 1'(i == words - 1)};
      exp_q.push_back(beat_x);
      txd_i <= beat_x;
      txd_valid_i <= 1'b1;
      @(posedge clk_i);
      for (w = 0; w < 50 && !txd_ready_o; w++) @(posedge clk_i);
      `CHK(w < 50, 1'b1)
    end
    txd_valid_i <= 1'b0;
    cnt_q.push_back(total);
  endtask : send_frame
  always @(posedge clk_i) begin
    if (irq_ptp_tx_o === 1'b1) tx_irqs++;
    if (irq_ptp_rx_o === 1'b1) rx_irqs++;
    // One count per byte beat: it stands for two cycles, one of each clock phase
    if (bridging_rx_stream_valid_o && bridging_rx_stream_clk_o) begin
      rx_beats++;
      brx_x = bridging_rx_stream_o;
    end
    if (rxd_valid_o && rxd_ready_i) begin
      got_x = exp_q.pop_front();
      `CHK(rxd_o, got_x)
    end
    if (rxs_valid_o && rxs_ready_i) begin
      stat_x = '{cnt_q.pop_front(), 4'hf, 1'b1};
      `CHK(rxs_o, stat_x)
    end
  end
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(32'h96be280d));
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(mgmt_present_o, 1'b1)
    `CHK(refclk_used_o, 1'b0)
    `CHK(mdio_oe_b_o, 1'b1)
    // Lone address with no data must not be taken
    s_axi_awvalid_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(s_axi_awready_o, 1'b0)
    s_axi_awvalid_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      t0 = 32'($urandom) & 32'hfffffffc;
      lite_write(t0, 32'($urandom), i < 2 ? {4{i[0]}} : 4'($urandom));
      lite_read(t0);
    end
    for (int i = 0; i < 6; i++) send_frame(i == 0 ? 1 : 1 + $urandom % 5, i < 2 ? i[0] : 1'($urandom));
    repeat (60) @(posedge clk_i);
    `CHK(exp_q.size(), 0)
    `CHK(tx_irqs, marks)
    `CHK(rx_irqs, marks)
    txd_rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(txd_ready_o, 1'b0)
    `CHK(txc_ready_o, 1'b1)
    txd_rst_b_i <= 1'b1;
    txc_rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(txd_ready_o, 1'b1)
    `CHK(txc_ready_o, 1'b0)
    txc_rst_b_i <= 1'b1;
    rxd_rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(txd_ready_o, 1'b0)
    `CHK(rxd_valid_o, 1'b0)
    rxd_rst_b_i <= 1'b1;
    bb = '{8'($urandom), 1'b0, 1'b1};
    bridging_tx_stream_i <= bb;
    bridging_tx_stream_valid_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(bridging_tx_stream_ready_o, 1'b1)
    bridging_tx_stream_valid_i <= 1'b0;
    bridging_tx_stream_rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(bridging_tx_stream_ready_o, 1'b0)
    bridging_tx_stream_rst_b_i <= 1'b1;
    t0 = rtc_o.ns;
    ticks = 0;
    edges = 0;
    iso_q = isochronous_tick_clock_o;
    mdcs = 0;
    mdc_q = mdc_o;
    repeat (2500) begin
      @(posedge clk_i);
      if (mdc_o !== mdc_q) mdcs++;
      mdc_q = mdc_o;
      if (irq_ptp_timer_o === 1'b1) ticks++;
      if (isochronous_tick_clock_o !== iso_q) edges++;
      iso_q = isochronous_tick_clock_o;
    end
    `CHK(rtc_o.ns - t0, 32'd250000)
    `CHK(ticks, 25)
    `CHK(edges, 4)
    `CHK(mdcs, 625)
    `CHK(rx_beats, 1)
    `CHK(brx_x, bb)
    conclude();
  end
endmodule : ethernet_host_side_ports_test
